// ===== inc/ivp_pkg.sv
// shared constants for the interrupt vector prioritizer
package ivp_pkg;
  localparam int          SLOT_CNT       = 32;
  localparam int          SLOT_W         = 5;
  localparam int          ADDR_W         = 16;
  localparam int          BYTE_W         = 8;
  localparam logic [15:0] VEC_FIRST_ADDR = 16'hFFC0;
  localparam logic [15:0] VEC_LAST_ADDR  = 16'hFFFE;
  localparam logic [9:0]  VEC_PAGE       = 10'h3FF;
  localparam int          VEC_PAGE_LSB   = 6;
  localparam int          VEC_SLOT_LSB   = 1;
  localparam logic [31:0] SLOTS_IN_USE   = 32'h47B7_F86B;
  localparam logic        MASK_RESET     = 1'b1;
  localparam logic        FLAG_RESET     = 1'b0;
  localparam logic [15:0] ROUTINE_RESET  = 16'h0000;
  typedef enum logic [0:0] {ST_RUN, ST_SERVICE} vec_state_type;
endpackage

// ===== inc/ivp_src_if.sv
// carrier between the top and one source gate
`timescale 1ns/1ps
interface ivp_src_if;
  logic event_hit;
  logic flag_clear;
  logic enable;
  logic flag;
  logic req;
  modport gate (input event_hit, input flag_clear, input enable, output flag, output req);
  modport top  (output event_hit, output flag_clear, output enable, input flag, input req);
endinterface

// ===== core/source_gate.sv
// one interrupt source: sticky flag and qualified request
`timescale 1ns/1ps
module source_gate #(
  parameter bit IN_USE = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // source link
  ivp_src_if.gate  src
);
  typedef struct packed {
    logic flag;
    logic req;
  } gate_state_type;

  gate_state_type st_r;
  gate_state_type st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.flag = (st_r.flag & ~src.flag_clear) | src.event_hit;
    st_nxt.req  = IN_USE & st_nxt.flag & src.enable;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r.flag <= ivp_pkg::FLAG_RESET;
      st_r.req  <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign src.flag = st_r.flag;
  assign src.req  = st_r.req;
endmodule

// ===== core/interrupt_vector_prioritizer.sv
// interrupt vector prioritizer: flags, priority pick, vector table and global mask
`timescale 1ns/1ps
module interrupt_vector_prioritizer #(
  parameter logic [31:0] SLOTS_IN_USE = ivp_pkg::SLOTS_IN_USE
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // peripheral sources
  input  wire logic [31:0] src_event,
  input  wire logic [31:0] src_clear,
  input  wire logic [31:0] src_enable,
  output logic      [31:0] src_flag,
  // processor side
  input  wire logic        stack_done,
  input  wire logic        mask_set,
  input  wire logic        mask_clear,
  output logic             irq_req,
  output logic             irq_qualified,
  output logic             global_mask,
  output logic             vector_valid,
  output logic      [4:0]  vector_slot,
  output logic      [15:0] vector_addr,
  output logic      [15:0] vector_routine,
  // vector table read
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  // vector table load
  input  wire logic        tbl_wr,
  input  wire logic [4:0]  tbl_slot,
  input  wire logic [15:0] tbl_routine
);
  typedef struct packed {
    ivp_pkg::vec_state_type state;
    logic                   irq;
    logic                   qualified;
    logic                   mask;
    logic                   vec_valid;
    logic [4:0]             slot;
    logic [15:0]            vec_addr;
    logic [15:0]            routine;
    logic [7:0]             rd_data;
    logic                   rd_valid;
  } top_state_type;

  top_state_type st_r;
  top_state_type st_nxt;
  logic [15:0]   routine_mem [ivp_pkg::SLOT_CNT];
  logic [31:0]   req_vec;
  logic [31:0]   flag_vec;
  logic [4:0]    win_slot;
  logic [4:0]    rd_slot;
  logic          rd_hit;

  genvar gi;
  generate
    for (gi = 0; gi < ivp_pkg::SLOT_CNT; gi++)
    begin : g_src
      ivp_src_if link ();
      assign link.event_hit  = src_event[gi];
      assign link.flag_clear = src_clear[gi];
      assign link.enable     = src_enable[gi];
      assign flag_vec[gi]    = link.flag;
      assign req_vec[gi]     = link.req;
      source_gate #(
        .IN_USE (SLOTS_IN_USE[gi])
      ) u_gate (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .src   (link.gate)
      );
    end
  endgenerate

  // lowest pending slot number wins
  always_comb
  begin
    win_slot = 5'h1F;
    for (int i = ivp_pkg::SLOT_CNT - 1; i >= 0; i--)
    begin
      if (req_vec[i])
      begin
        win_slot = 5'(i);
      end
    end
  end

  // slot 31 sits lowest in memory, slot 0 highest
  assign rd_hit  = rd_addr[15:ivp_pkg::VEC_PAGE_LSB] == ivp_pkg::VEC_PAGE;
  assign rd_slot = ~rd_addr[ivp_pkg::VEC_PAGE_LSB-1:ivp_pkg::VEC_SLOT_LSB];

  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.irq       = |req_vec;
    st_nxt.vec_valid = 1'b0;
    st_nxt.rd_valid  = rd_en;
    st_nxt.rd_data   = 8'h00;
    if (rd_en && rd_hit)
    begin
      st_nxt.rd_data = rd_addr[0] ? routine_mem[rd_slot][7:0] : routine_mem[rd_slot][15:8];
    end
    if (mask_clear)
    begin
      st_nxt.mask = 1'b0;
    end
    if (mask_set)
    begin
      st_nxt.mask = 1'b1;
    end
    case (st_r.state)
      ivp_pkg::ST_RUN:
      begin
        if (stack_done && (|req_vec))
        begin
          st_nxt.mask      = 1'b1;
          st_nxt.vec_valid = 1'b1;
          st_nxt.slot      = win_slot;
          st_nxt.vec_addr  = 16'(ivp_pkg::VEC_LAST_ADDR - {10'h000, win_slot, 1'b0});
          st_nxt.routine   = routine_mem[win_slot];
          st_nxt.state     = ivp_pkg::ST_SERVICE;
        end
      end
      ivp_pkg::ST_SERVICE:
      begin
        if (!st_nxt.mask)
        begin
          st_nxt.state = ivp_pkg::ST_RUN;
        end
      end
      default:
      begin
        st_nxt.state = ivp_pkg::ST_RUN;
      end
    endcase
    st_nxt.qualified = (|req_vec) & ~st_nxt.mask;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r.state     <= ivp_pkg::ST_RUN;
      st_r.irq       <= 1'b0;
      st_r.qualified <= 1'b0;
      st_r.mask      <= ivp_pkg::MASK_RESET;
      st_r.vec_valid <= 1'b0;
      st_r.slot      <= 5'h00;
      st_r.vec_addr  <= ivp_pkg::VEC_LAST_ADDR;
      st_r.routine   <= ivp_pkg::ROUTINE_RESET;
      st_r.rd_data   <= 8'h00;
      st_r.rd_valid  <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && tbl_wr)
    begin
      routine_mem[tbl_slot] <= tbl_routine;
    end
  end

  assign src_flag       = flag_vec;
  assign irq_req        = st_r.irq;
  assign irq_qualified  = st_r.qualified;
  assign global_mask    = st_r.mask;
  assign vector_valid   = st_r.vec_valid;
  assign vector_slot    = st_r.slot;
  assign vector_addr    = st_r.vec_addr;
  assign vector_routine = st_r.routine;
  assign rd_data        = st_r.rd_data;
  assign rd_valid       = st_r.rd_valid;

  AST_PRIORITY_PICK: assert property (@(posedge clk) disable iff (!rst_n)
    vector_valid |-> (($past(req_vec) >> vector_slot) & 32'h0000_0001) == 32'h0000_0001
      && (($past(req_vec) & ((32'h0000_0001 << vector_slot) - 32'h0000_0001)) == 32'h0000_0000))
    else $error("vector slot is not the lowest pending request");

  AST_VEC_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
    vector_valid |-> vector_addr == 16'(ivp_pkg::VEC_LAST_ADDR - {10'h000, vector_slot, 1'b0})
      && vector_addr >= ivp_pkg::VEC_FIRST_ADDR)
    else $error("vector address does not match its slot");

  AST_BYTE_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rd_en && rd_hit && !rd_addr[0] && !(tbl_wr && tbl_slot == rd_slot)
      |=> rd_data == $past(routine_mem[rd_slot][15:8]) && rd_valid)
    else $error("even vector byte is not the routine high byte");

  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    ce && (src_event != 32'h0000_0000) |=> (src_flag & $past(src_event)) == $past(src_event))
    else $error("event did not set its flag");

  AST_REQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    ce ##1 ce && ((src_flag & src_enable & $past(src_enable) & SLOTS_IN_USE) != 32'h0000_0000) |=> irq_req)
    else $error("flagged enabled source did not raise a request");

  AST_STACK_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    ce && stack_done && (|req_vec) && st_r.state == ivp_pkg::ST_RUN
      |=> global_mask && vector_valid ##1 !vector_valid)
    else $error("stacking did not set mask and present one vector");

  AST_RESET_MASK: assert property (@(posedge clk)
    !rst_n |=> global_mask && !irq_req && !vector_valid)
    else $error("mask not set after reset");

  AST_UNUSED_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    (req_vec & ~SLOTS_IN_USE) == 32'h0000_0000)
    else $error("unused slot raised a request");

  AST_QUALIFIED: assert property (@(posedge clk) disable iff (!rst_n)
    irq_qualified |-> irq_req && !global_mask)
    else $error("qualified request while masked");
endmodule

// ===== dv/cpu_model.sv
// processor model: stacks then asks for a vector on a qualified request
`timescale 1ns/1ps
module cpu_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // controller side
  input  wire logic       irq_qualified,
  input  wire logic [1:0] slow,
  output logic            stack_done
);
  logic [1:0] wait_r;
  logic       busy_r;
  always_ff @(posedge clk)
  begin
    stack_done <= 1'b0;
    if (!rst_n || !irq_qualified)
    begin
      wait_r <= 2'h0;
      busy_r <= 1'b0;
    end
    else if (!busy_r && wait_r == slow)
    begin
      stack_done <= 1'b1;
      busy_r     <= 1'b1;
    end
    else
      wait_r <= wait_r + 2'h1;
  end
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the interrupt vector prioritizer
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [31:0] src_event = '0, src_clear = '0, src_enable = '0, src_flag;
  logic        stack_done, mask_set = 1'b0, mask_clear = 1'b0;
  logic        irq_req, irq_qualified, global_mask, vector_valid, rd_valid;
  logic [4:0]  vector_slot, tbl_slot = '0;
  logic [15:0] vector_addr, vector_routine, tbl_routine = '0, rd_addr = '0;
  logic [7:0]  rd_data;
  logic        rd_en = 1'b0, tbl_wr = 1'b0;
  logic [1:0]  slow = '0;
  logic [15:0] tbl [32];
  logic [36:0] exp_vec [$];
  logic [7:0]  exp_rd [$];
  int          fail_count = 0, compares = 0;

  interrupt_vector_prioritizer dut (.clk, .rst_n, .ce, .src_event, .src_clear, .src_enable, .src_flag,
    .stack_done, .mask_set, .mask_clear, .irq_req, .irq_qualified, .global_mask, .vector_valid,
    .vector_slot, .vector_addr, .vector_routine, .rd_en, .rd_addr, .rd_data, .rd_valid,
    .tbl_wr, .tbl_slot, .tbl_routine);
  cpu_model cpu (.clk, .rst_n, .irq_qualified, .slow, .stack_done);

  always #12.5 clk = ~clk;

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input string name, input logic [36:0] exp, input logic [36:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(negedge clk)
  begin
    if (rst_n && vector_valid === 1'b1)
      chk("vector", exp_vec.size() ? exp_vec.pop_front() : 'x, {vector_slot, vector_addr, vector_routine});
    if (rst_n && rd_valid === 1'b1)
      chk("rd_data", exp_rd.size() ? exp_rd.pop_front() : 'x, rd_data);
  end

  initial
  begin
    #(25 * 20000);
    fail_count++;
    test_done();
  end

  initial
  begin
    logic [31:0] ev, en, pend;
    int w, n;
    void'($urandom(32'h63c1));
    tick(8);
    rst_n = 1'b1;
    tick();
    chk("global_mask", 1'b1, global_mask);
    chk("irq_req", 1'b0, irq_req);
    for (int s = 0; s < 32; s++)
    begin
      tbl[s] = 16'($urandom);
      tbl_wr = 1'b1;
      tbl_slot = 5'(s);
      tbl_routine = tbl[s];
      tick();
    end
    tbl_wr = 1'b0;
    for (int a = 32'hFFBE; a <= 32'hFFFF; a++)
    begin
      rd_en = 1'b1;
      rd_addr = 16'(a);
      exp_rd.push_back(a < 32'hFFC0 ? 8'h00 : (a[0] ? tbl[31 - a[5:1]][7:0] : tbl[31 - a[5:1]][15:8]));
      tick();
    end
    rd_en = 1'b0;
    repeat (6)
    begin
      ev = $urandom;
      en = $urandom;
      slow = 2'($urandom);
      pend = ev & en & ivp_pkg::SLOTS_IN_USE;
      src_enable = en;
      src_event = ev;
      tick();
      src_event = '0;
      tick(3);
      chk("src_flag", ev, src_flag);
      chk("irq_req", |pend, irq_req);
      mask_clear = 1'b1;
      tick();
      mask_clear = 1'b0;
      chk("irq_qualified", |pend, irq_qualified);
      while (pend != 0)
      begin
        w = 0;
        while (!pend[w])
          w++;
        exp_vec.push_back({5'(w), 16'hFFFE - 16'(2 * w), tbl[w]});
        for (n = 0; n < 40 && vector_valid !== 1'b1; n++)
          tick();
        chk("vector_valid", 1'b1, vector_valid);
        tick();
        chk("global_mask", 1'b1, global_mask);
        src_clear = 32'h1 << w;
        tick();
        src_clear = '0;
        tick(3);
        pend[w] = 1'b0;
        mask_clear = 1'b1;
        tick();
        mask_clear = 1'b0;
      end
      tick(3);
      chk("irq_req", 1'b0, irq_req);
      chk("src_flag", ev & ~(en & ivp_pkg::SLOTS_IN_USE), src_flag);
      src_clear = '1;
      mask_set = 1'b1;
      tick();
      src_clear = '0;
      mask_set = 1'b0;
      tick(2);
    end
    ce = 1'b0;
    src_event = '1;
    mask_clear = 1'b1;
    tick(2);
    chk("frozen_flag", 32'h0, src_flag);
    chk("frozen_mask", 1'b1, global_mask);
    ce = 1'b1;
    src_event = '0;
    mask_clear = 1'b1;
    tick();
    mask_clear = 1'b0;
    rst_n = 1'b0;
    tick();
    rst_n = 1'b1;
    tick();
    chk("global_mask", 1'b1, global_mask);
    chk("leftover", 37'h0, 37'(exp_vec.size() + exp_rd.size()));
    test_done();
  end
endmodule
